/* aols_pkg.sv */
// shared constants and carrier types for the output latency sequencer
package aols_pkg;

  // sample and bus widths
  localparam int SAMPLE_W = 12;
  localparam int APB_ADDR_W = 8;

  // pipeline latency in sampling clock cycles, whole-cycle taps
  localparam int LAT_PRIMARY = 34;
  localparam int LAT_DELAYED = 35;
  // a falling-edge sample sits half a cycle after its rising partner: one extra slot
  localparam int LAT_FALL_EXTRA = 1;
  localparam int LINE_DEPTH = LAT_DELAYED + LAT_FALL_EXTRA;
  // constant output delay, one register stage behind the fifo
  localparam int OUTPUT_DELAY_CYC = 1;
  localparam int FIFO_DEPTH = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STALLS = 8'h08;

  // config field positions
  localparam int CFG_INTERLEAVE_BIT = 0;
  localparam int CFG_DEMUX_BIT = 1;
  localparam int CFG_EXT_CTRL_BIT = 2;
  localparam int CFG_SEL_LSB = 4;

  // status field positions
  localparam int STS_PRIMED_BIT = 0;
  localparam int STS_FULL_BIT = 1;
  localparam int STS_EMPTY_BIT = 2;
  localparam int STS_SEL_LSB = 4;

  // reset values
  localparam logic RST_INTERLEAVE = 1'b0;
  localparam logic RST_DEMUX = 1'b1;
  localparam logic RST_EXT_CTRL = 1'b0;

  // interleaved input selection; the fourth code is illegal
  typedef enum logic [1:0] {
    interleave_from_i_input,
    interleave_from_q_input,
    interleave_from_both_inputs
  } aols_sel_t;

  // register decode result
  typedef enum logic [1:0] {
    aols_reg_config,
    aols_reg_status,
    aols_reg_stalls,
    aols_reg_none
  } aols_reg_t;

  // one captured slot: rising-edge word and second word, q-rise or a falling edge
  typedef struct packed {
    logic [SAMPLE_W-1:0] rise;
    logic [SAMPLE_W-1:0] other;
  } aols_pair_t;

  // four-bus output word
  typedef struct packed {
    logic [SAMPLE_W-1:0] i_primary;
    logic [SAMPLE_W-1:0] q_primary;
    logic [SAMPLE_W-1:0] i_delayed;
    logic [SAMPLE_W-1:0] q_delayed;
    logic delayed_en;
  } aols_word_t;

  localparam int WORD_W = $bits(aols_word_t);

endpackage : aols_pkg

/* aols_fifo.sv */
// parameterised valid/ready fifo for the output word path
module aols_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } aols_fifo_state_t;

  aols_fifo_state_t state;
  aols_fifo_state_t next_state;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready_out = (state.count != FULL_COUNT);
  assign out_valid_out = (state.count != '0);
  assign out_data_out = state.mem[state.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = in_data_in;
      next_state.wr_ptr = (state.wr_ptr == LAST_PTR) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = (state.rd_ptr == LAST_PTR) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  // storage is not cleared on reset, only the pointers and the count
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state.wr_ptr <= '0;
      state.rd_ptr <= '0;
      state.count <= '0;
      state.mem <= state.mem;
    end else begin
      state <= next_state;
    end
  end

endmodule : aols_fifo

/* aols_sequencer.sv */
// converter sample capture, latency delay line and four-bus output sequencer
//
// Contract
// - Normal mode takes one sample per rising clock edge; interleaved mode takes rising and falling samples.
// - Each result leaves on its bus a fixed mode-dependent number of accepted samples after capture, plus a constant output delay.
// - Demux normal mode: primary I/Q carry rising samples 34 cycles old, delayed I/Q carry them 35 cycles old.
// - Demux interleaved: rising samples on primary I at 34 and delayed I at 35, falling on primary Q at 34.5 and delayed Q at 35.5.
// - Non-demux mode drives only primary I and Q (Q at 34.5 when interleaved) and leaves both delayed buses undriven.
// - Q-input selection in interleaved mode is honoured only with extended control mode; otherwise the I input is used.
// - Two configurations exist: two channels at base rate, or one interleaved channel at twice that rate.
// - Interleaved mode offers I only, Q only or both inputs, with I only as the default.
//
// The APB register port and the register addresses were left to the implementer.
module aols_sequencer
  import aols_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W,
  parameter int DEPTH_WORDS = FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // converter core samples, same clock
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] i_rise_in,
  input wire logic [SAMPLE_W-1:0] i_fall_in,
  input wire logic [SAMPLE_W-1:0] q_rise_in,
  input wire logic [SAMPLE_W-1:0] q_fall_in,
  output logic sample_ready_out,
  // output buses toward the capture logic
  output logic [SAMPLE_W-1:0] i_primary_bus_out,
  output logic [SAMPLE_W-1:0] q_primary_bus_out,
  output logic [SAMPLE_W-1:0] i_delayed_bus_out,
  output logic [SAMPLE_W-1:0] q_delayed_bus_out,
  output logic i_delayed_oe_n_out,
  output logic q_delayed_oe_n_out,
  output logic bus_valid_out,
  input wire logic bus_ready_in
);

  localparam int FILL_W = $clog2(LINE_DEPTH + 1);
  localparam logic [FILL_W-1:0] FILL_DONE = FILL_W'(LINE_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic interleave;
    logic demux;
    logic ext_ctrl;
    logic [1:0] sel_raw;
    aols_pair_t [LINE_DEPTH-1:0] line;
    logic [FILL_W-1:0] fill;
    logic [31:0] stalls;
    aols_word_t out_word;
    logic out_valid;
    logic delayed_oe_n;
    logic ready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } aols_state_t;

  aols_state_t state;
  aols_state_t next_state;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic fifo_push;
  aols_word_t push_word;
  aols_sel_t sel_eff;
  aols_pair_t captured;
  logic advance;
  logic primed;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // register decode, shared by read and write paths
  function automatic aols_reg_t aols_decode(input logic [APB_ADDR_W-1:0] addr);
    aols_reg_t r;
    r = aols_reg_none;
    if (addr == APB_ADDR_W'(OFS_CONFIG)) begin
      r = aols_reg_config;
    end else if (addr == APB_ADDR_W'(OFS_STATUS)) begin
      r = aols_reg_status;
    end else if (addr == APB_ADDR_W'(OFS_STALLS)) begin
      r = aols_reg_stalls;
    end
    return r;
  endfunction : aols_decode

  // the q input is refused without extended control; illegal code falls back to i
  always_comb begin
    sel_eff = interleave_from_i_input;
    if (state.ext_ctrl) begin
      unique case (state.sel_raw)
        2'h1: sel_eff = interleave_from_q_input;
        2'h2: sel_eff = interleave_from_both_inputs;
        default: sel_eff = interleave_from_i_input;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample capture

  // rise slot always from a rising edge; other slot is q-rise or a falling edge
  always_comb begin
    captured.rise = i_rise_in;
    captured.other = q_rise_in;
    if (state.interleave) begin
      unique case (sel_eff)
        interleave_from_i_input: begin
          captured.rise = i_rise_in;
          captured.other = i_fall_in;
        end
        interleave_from_q_input: begin
          captured.rise = q_rise_in;
          captured.other = q_fall_in;
        end
        interleave_from_both_inputs: begin
          // both inputs carry the same signal, rising from i and falling from q
          captured.rise = i_rise_in;
          captured.other = q_fall_in;
        end
      endcase
    end
  end

  // a full fifo stalls the line, so latency holds only while the drain keeps up
  assign advance = sample_valid_in && fifo_in_ready;
  assign primed = (state.fill == FILL_DONE);
  assign fifo_push = advance && primed;

  ////////////////////////////////////////////////////////////////////////////
  // latency taps

  // line[k] holds the slot captured k+1 advances before this one
  always_comb begin
    push_word.i_primary = state.line[LAT_PRIMARY-1].rise;
    push_word.i_delayed = state.line[LAT_DELAYED-1].rise;
    push_word.q_primary = state.line[LAT_PRIMARY-1].other;
    push_word.q_delayed = state.line[LAT_DELAYED-1].other;
    if (state.interleave) begin
      // falling samples trail by half a cycle, one slot further back
      push_word.q_primary = state.line[LAT_PRIMARY-1+LAT_FALL_EXTRA].other;
      push_word.q_delayed = state.line[LAT_DELAYED-1+LAT_FALL_EXTRA].other;
    end
    push_word.delayed_en = state.demux;
    if (!state.demux) begin
      push_word.i_delayed = '0;
      push_word.q_delayed = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;

    // delay line shifts once per accepted sample
    if (advance) begin
      next_state.line = {state.line[LINE_DEPTH-2:0], captured};
      if (!primed) begin
        next_state.fill = state.fill + 1'b1;
      end
    end

    // samples offered while stalled are lost; count them
    if (sample_valid_in && !fifo_in_ready) begin
      next_state.stalls = state.stalls + 32'h0000_0001;
    end
    next_state.ready = fifo_in_ready;

    // output register is the constant output delay stage
    if (!state.out_valid || bus_ready_in) begin
      next_state.out_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        next_state.out_word = aols_word_t'(fifo_out_data);
      end
    end
    // delayed buses float unless a valid demux word stands; kept in a flop so the pin is glitch free
    next_state.delayed_oe_n = !(next_state.out_valid && next_state.out_word.delayed_en);

    // apb: one wait state, then pready for exactly one cycle
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (psel_in && penable_in && !state.pready) begin
      next_state.pready = 1'b1;
      next_state.prdata = 32'h0000_0000;
      unique case (aols_decode(paddr_in))
        aols_reg_config: begin
          next_state.prdata[CFG_INTERLEAVE_BIT] = state.interleave;
          next_state.prdata[CFG_DEMUX_BIT] = state.demux;
          next_state.prdata[CFG_EXT_CTRL_BIT] = state.ext_ctrl;
          next_state.prdata[CFG_SEL_LSB+:2] = state.sel_raw;
        end
        aols_reg_status: begin
          next_state.prdata[STS_PRIMED_BIT] = primed;
          next_state.prdata[STS_FULL_BIT] = !fifo_in_ready;
          next_state.prdata[STS_EMPTY_BIT] = !fifo_out_valid;
          next_state.prdata[STS_SEL_LSB+:2] = sel_eff;
        end
        aols_reg_stalls: next_state.prdata = state.stalls;
        aols_reg_none: next_state.pslverr = 1'b1;
      endcase
    end

    // writes land on the edge where the master sees pready
    if (psel_in && penable_in && state.pready && pwrite_in) begin
      unique case (aols_decode(paddr_in))
        aols_reg_config: begin
          next_state.interleave = pwdata_in[CFG_INTERLEAVE_BIT];
          next_state.demux = pwdata_in[CFG_DEMUX_BIT];
          next_state.ext_ctrl = pwdata_in[CFG_EXT_CTRL_BIT];
          next_state.sel_raw = pwdata_in[CFG_SEL_LSB+:2];
        end
        aols_reg_stalls: next_state.stalls = 32'h0000_0000;
        aols_reg_status: next_state.stalls = next_state.stalls;
        aols_reg_none: next_state.stalls = next_state.stalls;
      endcase
      // an overflow in the clearing cycle survives the clear
      if (aols_decode(paddr_in) == aols_reg_stalls && sample_valid_in && !fifo_in_ready) begin
        next_state.stalls = 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= '0;
      state.interleave <= RST_INTERLEAVE;
      state.demux <= RST_DEMUX;
      state.ext_ctrl <= RST_EXT_CTRL;
      state.sel_raw <= 2'h0;
      state.delayed_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo between delay line and output register

  aols_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH_WORDS)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!state.out_valid || bus_ready_in),
    .out_data_out(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from state flops

  assign prdata_out = state.prdata;
  assign pready_out = state.pready;
  assign pslverr_out = state.pslverr;
  assign sample_ready_out = state.ready;
  assign bus_valid_out = state.out_valid;
  assign i_primary_bus_out = state.out_word.i_primary;
  assign q_primary_bus_out = state.out_word.q_primary;
  assign i_delayed_bus_out = state.out_word.i_delayed;
  assign q_delayed_bus_out = state.out_word.q_delayed;
  // undriven delayed buses in non-demux mode
  assign i_delayed_oe_n_out = state.delayed_oe_n;
  assign q_delayed_oe_n_out = state.delayed_oe_n;

endmodule : aols_sequencer

/* aols_properties.sv */
// port checker for the output latency sequencer, bound to its top
module aols_checker
  import aols_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] i_primary_bus_out,
  input wire logic i_delayed_oe_n_out,
  input wire logic q_delayed_oe_n_out,
  input wire logic bus_valid_out,
  input wire logic bus_ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] n_valid;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  // offered samples since reset, saturating so it never wraps
  always_ff @(posedge core_clk_in) begin
    if (rst_in) n_valid <= 6'h00;
    else if (sample_valid_in && n_valid != 6'h3f) n_valid <= n_valid + 6'h01;
  end
  chk_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  chk_pready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  chk_err_data: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error reply carries data");
  chk_word_held: assert property (bus_valid_out && !bus_ready_in |=> bus_valid_out && $stable(i_primary_bus_out))
    else $error("word dropped before taken");
  chk_idle_float: assert property (!bus_valid_out |-> i_delayed_oe_n_out)
    else $error("delayed bus driven while idle");
  chk_oe_pair: assert property (i_delayed_oe_n_out == q_delayed_oe_n_out)
    else $error("delayed enables differ");
  // the first word needs 37 accepted samples, so at least 37 were offered
  chk_line_fill: assert property (bus_valid_out |-> n_valid > 6'h24)
    else $error("word before line filled");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !bus_valid_out && !pready_out && i_delayed_oe_n_out)
    else $error("outputs active after reset");
endmodule : aols_checker
////////////////////////////////////////////////////////////
bind aols_sequencer aols_checker u_chk (.core_clk_in, .rst_in, .psel_in, .penable_in, .prdata_out, .pready_out,
  .pslverr_out, .sample_valid_in, .i_primary_bus_out, .i_delayed_oe_n_out, .q_delayed_oe_n_out, .bus_valid_out,
  .bus_ready_in);

/* aols_capture_model.sv */
// capture side model: accepts words from the four output buses
module aols_capture_model
  import aols_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [SAMPLE_W-1:0] ip_in,
  input wire logic [SAMPLE_W-1:0] qp_in,
  input wire logic [SAMPLE_W-1:0] id_in,
  input wire logic [SAMPLE_W-1:0] qd_in,
  input wire logic ioe_n_in,
  input wire logic qoe_n_in,
  output logic ready_out,
  output logic took_out,
  output aols_word_t word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SAMPLE_W-1:0] id_last, qd_last, id_wire, qd_wire;
  // a released bus floats: show the inverse of its last level
  assign id_wire = ioe_n_in ? ~id_last : id_in;
  assign qd_wire = qoe_n_in ? ~qd_last : qd_in;
  // ready lags the stall request by an edge, so stalls are slow
  always_ff @(posedge core_clk_in) begin
    ready_out <= !rst_in && !stall_in;
    took_out <= !rst_in && valid_in && ready_out;
    word_out <= '{ip_in, qp_in, id_wire, qd_wire, !ioe_n_in};
    id_last <= id_wire;
    qd_last <= qd_wire;
  end
endmodule : aols_capture_model

/* aols_tb.sv */
// self-checking bench for the output latency sequencer
module tb;
  import aols_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, pen, pwr, sv, stall, pready, er, srdy, ioe, qoe, bv, brdy, took, il, dm, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [11:0] ir, ifl, qr, qf, ip, qp, id, qd;
  logic [31:0] rs[0:63];
  logic [1:0] sel;
  logic [7:0] cfgs[8] = '{8'h02, 8'h03, 8'h13, 8'h17, 8'h27, 8'h37, 8'h01, 8'h00};
  aols_word_t word;
  aols_word_t got[$];
  int miscompares, n_compared, a;
  aols_sequencer DUT (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(er),
    .sample_valid_in(sv), .i_rise_in(ir), .i_fall_in(ifl), .q_rise_in(qr), .q_fall_in(qf),
    .sample_ready_out(srdy), .i_primary_bus_out(ip), .q_primary_bus_out(qp), .i_delayed_bus_out(id),
    .q_delayed_bus_out(qd), .i_delayed_oe_n_out(ioe), .q_delayed_oe_n_out(qoe), .bus_valid_out(bv),
    .bus_ready_in(brdy));
  aols_capture_model u_cap (.core_clk_in(clk), .rst_in(rst), .stall_in(stall), .valid_in(bv), .ip_in(ip),
    .qp_in(qp), .id_in(id), .qd_in(qd), .ioe_n_in(ioe), .qoe_n_in(qoe), .ready_out(brdy), .took_out(took),
    .word_out(word));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // words arrive registered, so the pre-edge value is settled
  always @(posedge clk) begin
    if (took === 1'b1) got.push_back(word);
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected slot content from the mode and effective selection
  function automatic logic [11:0] pick(input logic [31:0] r, input logic rise);
    if (!il) return rise ? r[11:0] : r[23:12];
    if (sel == 2'h1) return rise ? r[23:12] : ~r[23:12];
    if (sel == 2'h2) return rise ? r[11:0] : ~r[23:12];
    return rise ? r[11:0] : ~r[11:0];
  endfunction : pick
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  // the hang guard alone ends a wait that never sees pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    re = er;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  // offer n samples with random gaps, logging each offered one
  task automatic stream(input int n);
    a = 0;
    while (a < n) begin
      logic [31:0] r;
      @(posedge clk);
      r = rnd();
      sv <= r[31] | r[30];
      ir <= r[11:0];
      qr <= r[23:12];
      ifl <= ~r[11:0];
      qf <= ~r[23:12];
      if (r[31] | r[30]) begin
        rs[a] = r;
        a++;
      end
    end
    @(posedge clk);
    sv <= 1'b0;
  endtask : stream
  task automatic test_done();
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    {rst, psel, pen, pwr, sv, stall, paddr, pwdata} = {1'b1, 45'h0};
    {ir, ifl, qr, qf} = 48'h0;
    seed = 32'h618a6a39;
    miscompares = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk("config", 32'h2, rd);
    chk("config err", 32'h0, 32'(re));
    apb(1'b1, OFS_STATUS, 32'h3f);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h4, 32'({rd[5:4], rd[2:0]}));
    apb(1'b0, OFS_STALLS, 32'h0);
    chk("stalls", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(re));
    // every mode and selection, each from a fresh line
    foreach (cfgs[m]) begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b1, OFS_CONFIG, {24'h0, cfgs[m]});
      il = cfgs[m][0];
      dm = cfgs[m][1];
      sel = cfgs[m][2] && cfgs[m][5:4] != 2'h3 ? cfgs[m][5:4] : 2'h0;
      got.delete();
      stream(44);
      repeat (8) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("sel", 32'({sel, 3'h5}), 32'({rd[5:4], rd[2:0]}));
      chk("words", 32'h8, 32'(got.size()));
      foreach (got[k]) begin
        a = k + 36;
        chk("ip", 32'(pick(rs[a-34], 1'b1)), 32'(got[k].i_primary));
        chk("qp", 32'(pick(rs[a-34-il], 1'b0)), 32'(got[k].q_primary));
        chk("oe", 32'(dm), 32'(got[k].delayed_en));
        if (dm) begin
          chk("id", 32'(pick(rs[a-35], 1'b1)), 32'(got[k].i_delayed));
          chk("qd", 32'(pick(rs[a-35-il], 1'b0)), 32'(got[k].q_delayed));
        end
      end
    end
    // stall the capture side until the fifo refuses, then count drops
    stall <= 1'b1;
    stream(60);
    chk("ready", 32'h0, 32'(srdy));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("full", 32'h1, 32'(rd[1]));
    apb(1'b1, OFS_STALLS, 32'h0);
    stream(5);
    apb(1'b0, OFS_STALLS, 32'h0);
    chk("drops", 32'h5, rd);
    // a drop on the very edge of the clear must survive it
    fork
      apb(1'b1, OFS_STALLS, 32'h0);
      begin
        sv <= 1'b1;
        repeat (3) @(posedge clk);
        sv <= 1'b0;
      end
    join
    apb(1'b0, OFS_STALLS, 32'h0);
    chk("drop on clear", 32'h1, rd);
    stall <= 1'b0;
    repeat (30) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("drained", 32'h5, 32'(rd[2:0]));
    test_done();
  end
  // hang guard, far beyond the run length
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : tb
